// File: amx_core.v
`timescale 1ns/1ps
`include "amx_defs.vh"
module amx_core (
    input  wire         i_clk,
    input  wire         i_rst,
    input  wire         i_hsel,
    input  wire [31:0]  i_haddr,
    input  wire [1:0]   i_htrans,
    input  wire         i_hwrite,
    input  wire [2:0]   i_hsize,
    input  wire [31:0]  i_hwdata,
    input  wire         i_hready,
    output wire [31:0]  o_hrdata,
    output wire         o_hreadyout,
    output wire         o_hresp,
    input  wire         i_core_system_clock_ok,
    input  wire [15:0]  i_rate_tick,
    input  wire [95:0]  i_analog_in,
    input  wire [255:0] i_asp1_rx,
    input  wire [127:0] i_asp2_rx,
    input  wire [47:0]  i_ultrasonic_in,
    output wire [255:0] o_asp1_tx,
    output wire [127:0] o_asp2_tx,
    output wire [95:0]  o_eq_out,
    output wire         o_eq_valid
);
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;
    // bus front end
    reg         wr_ph_ff;
    reg         rd_ph_ff;
    reg         rd_done_ff;
    reg  [15:0] a_addr_ff;
    reg         a_hi_ok_ff;
    reg  [31:0] hrdata_ff;
    // register file
    reg  [8:0]  src_ff   [0:`AMX_NUM_SRCW-1];
    reg  [6:0]  gain_ff  [0:`AMX_NUM_SRCW-1];
    reg  [15:0] coef_ff  [0:`AMX_NUM_COEF-1];
    reg  [23:0] rate_ff;
    reg  [3:0]  eq_en_ff;
    reg  [3:0]  eq_mode_ff;
    // captured input paths
    reg  [23:0] ana_ff   [0:`AMX_NUM_ANA-1];
    reg  [31:0] asp1_ff  [0:`AMX_NUM_ASP1-1];
    reg  [31:0] asp2_ff  [0:`AMX_NUM_ASP2-1];
    reg  [23:0] us_ff    [0:1];
    // equalizer engine
    reg         eq_state_ff;
    reg         fx_go_ff;
    reg  [1:0]  eq_idx_ff;
    reg  [2:0]  band_ff;
    reg  [23:0] x_ff;
    reg  [23:0] lp_ff    [0:`AMX_NUM_STATE-1];
    reg  [23:0] bp_ff    [0:`AMX_NUM_STATE-1];
    reg  [23:0] eq_out_ff[0:`AMX_NUM_EQ-1];
    reg         eq_valid_ff;
    wire [3:0]  in_rate   = rate_ff[`AMX_RATE_IN_LSB   +: 4];
    wire [3:0]  asp1_rate = rate_ff[`AMX_RATE_ASP1_LSB +: 4];
    wire [3:0]  asp2_rate = rate_ff[`AMX_RATE_ASP2_LSB +: 4];
    wire [3:0]  us1_rate  = rate_ff[`AMX_RATE_US1_LSB  +: 4];
    wire [3:0]  us2_rate  = rate_ff[`AMX_RATE_US2_LSB  +: 4];
    wire [3:0]  effects_rate   = rate_ff[`AMX_RATE_FX_LSB   +: 4];
    function [15:0] mix_addr;
        input integer k;
        integer m;
        integer a;
        begin
            m = k / `AMX_NUM_IN;
            if (m < `AMX_FIRST_ASP2_MIX)
                a = `AMX_ASP1_MIX_BASE + m * `AMX_MIX_STRIDE;
            else if (m < `AMX_FIRST_EQ_MIX)
                a = `AMX_ASP2_MIX_BASE + (m - `AMX_FIRST_ASP2_MIX) * `AMX_MIX_STRIDE;
            else
                a = `AMX_EQ_MIX_BASE + (m - `AMX_FIRST_EQ_MIX) * `AMX_MIX_STRIDE;
            a = a + (k % `AMX_NUM_IN) * `AMX_WORD_BYTES;
            mix_addr = a[15:0];
        end
    endfunction
    function [15:0] coef_addr;
        input integer k;
        integer a;
        begin
            a = `AMX_EQ_COEF_BASE + (k / `AMX_COEF_PER_EQ) * `AMX_EQ_COEF_STRIDE
                + (k % `AMX_COEF_PER_EQ) * `AMX_WORD_BYTES;
            coef_addr = a[15:0];
        end
    endfunction
    function signed [47:0] sat24;
        input signed [47:0] v;
        begin
            if (v > $signed(48'h0000007FFFFF))
                sat24 = 48'h0000007FFFFF;
            else if (v < $signed(48'hFFFFFF800000))
                sat24 = 48'hFFFFFF800000;
            else
                sat24 = v;
        end
    endfunction
    // address decode on the latched address phase
    reg         src_hit;
    reg  [5:0]  src_idx;
    reg         gain_hit;
    reg  [5:0]  gain_idx;
    reg         coef_hit;
    reg  [5:0]  coef_idx;
    integer     j;
    integer     jd;
    always @* begin
        src_hit  = 1'b0;
        src_idx  = 6'h0;
        gain_hit = 1'b0;
        gain_idx = 6'h0;
        coef_hit = 1'b0;
        coef_idx = 6'h0;
        for (jd = 0; jd < `AMX_NUM_SRCW; jd = jd + 1) begin
            if (a_hi_ok_ff && a_addr_ff == mix_addr(jd)) begin // R4 R5
                src_hit = 1'b1;
                src_idx = jd[5:0];
            end
            if (a_hi_ok_ff && a_addr_ff == mix_addr(jd) + `AMX_GAIN_BANK) begin
                gain_hit = 1'b1;
                gain_idx = jd[5:0];
            end
        end
        for (jd = 0; jd < `AMX_NUM_COEF; jd = jd + 1) begin
            if (a_hi_ok_ff && a_addr_ff == coef_addr(jd)) begin // R16
                coef_hit = 1'b1;
                coef_idx = jd[5:0];
            end
        end
    end
    wire rate_hit = a_hi_ok_ff && a_addr_ff == `AMX_RATE_ADDR;
    wire en_hit   = a_hi_ok_ff && a_addr_ff == `AMX_EQ_EN_ADDR;
    wire mode_hit = a_hi_ok_ff && a_addr_ff == `AMX_EQ_MODE_ADDR;

    reg [31:0] rd_val;
    always @* begin
        rd_val = 32'h0;
        if (src_hit) begin
            rd_val[8:0] = src_ff[src_idx];
            rd_val[`AMX_STS_BIT] = src_ff[src_idx] != `AMX_SRC_SILENCE; // R10 R21
        end
        if (gain_hit)
            rd_val[7:1] = gain_ff[gain_idx]; // R20
        if (coef_hit)
            rd_val[15:0] = coef_ff[coef_idx];
        if (rate_hit)
            rd_val[`AMX_RATE_BITS-1:0] = rate_ff;
        if (en_hit)
            rd_val[3:0] = eq_en_ff;
        if (mode_hit)
            rd_val[3:0] = eq_mode_ff;
    end

    // one wait state on reads so read data leaves a flop; writes are zero-wait
    wire a_take = i_hsel & i_hready & i_htrans[1];
    always @(posedge i_clk) begin
        if (i_rst) begin
            wr_ph_ff   <= 1'b0;
            rd_ph_ff   <= 1'b0;
            rd_done_ff <= 1'b0;
            a_addr_ff  <= 16'h0;
            a_hi_ok_ff <= 1'b0;
            hrdata_ff  <= 32'h0;
        end else if (i_hready) begin
            wr_ph_ff   <= a_take & i_hwrite;
            rd_ph_ff   <= a_take & ~i_hwrite;
            rd_done_ff <= 1'b0;
            if (a_take) begin
                a_addr_ff  <= i_haddr[15:0];
                a_hi_ok_ff <= i_haddr[31:16] == 16'h0;
            end
        end else if (rd_ph_ff) begin
            rd_done_ff <= 1'b1;
            hrdata_ff  <= rd_val;
        end
    end
    assign o_hreadyout = ~(rd_ph_ff & ~rd_done_ff);
    assign o_hrdata    = hrdata_ff;
    assign o_hresp     = 1'b0;

    // a write that would turn a silent input on is dropped while the clock is too slow;
    // re-routing a live input or muting it is always accepted
    wire src_refuse = (src_ff[src_idx] == `AMX_SRC_SILENCE) &&
                      (i_hwdata[8:0] != `AMX_SRC_SILENCE) && !i_core_system_clock_ok; // R9
    always @(posedge i_clk) begin
        if (i_rst) begin
            for (j = 0; j < `AMX_NUM_SRCW; j = j + 1) begin
                src_ff[j]  <= `AMX_SRC_SILENCE;
                gain_ff[j] <= `AMX_GAIN_RST; // R20
            end
            for (j = 0; j < `AMX_NUM_COEF; j = j + 1)
                coef_ff[j] <= 16'h0;
            rate_ff    <= 24'h0;
            eq_en_ff   <= 4'h0;
            eq_mode_ff <= 4'h0;
        end else if (wr_ph_ff) begin
            if (src_hit && !src_refuse)
                src_ff[src_idx] <= i_hwdata[8:0]; // R9
            if (gain_hit)
                gain_ff[gain_idx] <= i_hwdata[7:1];
            if (coef_hit)
                coef_ff[coef_idx] <= i_hwdata[15:0];
            if (rate_hit)
                rate_ff <= i_hwdata[`AMX_RATE_BITS-1:0];
            if (en_hit)
                eq_en_ff <= i_hwdata[3:0];
            if (mode_hit)
                eq_mode_ff <= i_hwdata[3:0];
        end
    end

    // each input group is sampled on the tick of its own rate field
    always @(posedge i_clk) begin
        if (i_rst) begin
            for (j = 0; j < `AMX_NUM_ANA; j = j + 1)
                ana_ff[j] <= 24'h0;
            for (j = 0; j < `AMX_NUM_ASP1; j = j + 1)
                asp1_ff[j] <= 32'h0;
            for (j = 0; j < `AMX_NUM_ASP2; j = j + 1)
                asp2_ff[j] <= 32'h0;
            us_ff[0] <= 24'h0;
            us_ff[1] <= 24'h0;
        end else begin
            if (i_rate_tick[in_rate]) // R19
                for (j = 0; j < `AMX_NUM_ANA; j = j + 1)
                    ana_ff[j] <= i_analog_in[j*24 +: 24];
            if (i_rate_tick[asp1_rate]) // R19
                for (j = 0; j < `AMX_NUM_ASP1; j = j + 1)
                    asp1_ff[j] <= i_asp1_rx[j*32 +: 32];
            if (i_rate_tick[asp2_rate]) // R19
                for (j = 0; j < `AMX_NUM_ASP2; j = j + 1)
                    asp2_ff[j] <= i_asp2_rx[j*32 +: 32];
            if (i_rate_tick[us1_rate]) // R19
                us_ff[0] <= i_ultrasonic_in[23:0];
            if (i_rate_tick[us2_rate]) // R19
                us_ff[1] <= i_ultrasonic_in[47:24];
        end
    end

    // source selection per mixer input; 24-bit paths are left-aligned in 32 bits
    wire [2047:0] smp_bus;
    wire [447:0]  gain_bus;
    wire [511:0]  mix_bus;
    genvar g;
    generate
        for (g = 0; g < `AMX_NUM_SRCW; g = g + 1) begin : g_src
            reg [31:0] smp;
            always @* begin
                smp = 32'h0;
                if ((src_ff[g] & `AMX_SRC_ANA_MASK) == `AMX_SRC_ANA_BASE)
                    smp = {ana_ff[src_ff[g][1:0]], 8'h00}; // R1
                else if ((src_ff[g] & `AMX_SRC_ASP1_MASK) == `AMX_SRC_ASP1_BASE)
                    smp = asp1_ff[src_ff[g][2:0]]; // R1
                else if ((src_ff[g] & `AMX_SRC_ASP2_MASK) == `AMX_SRC_ASP2_BASE)
                    smp = asp2_ff[src_ff[g][1:0]]; // R2
                else if ((src_ff[g] & `AMX_SRC_US_MASK) == `AMX_SRC_US_BASE)
                    smp = {us_ff[src_ff[g][0]], 8'h00}; // R2
            end
            assign smp_bus[g*32 +: 32] = smp;
            assign gain_bus[g*7 +: 7]  = gain_ff[g];
        end
        for (g = 0; g < `AMX_NUM_MIX; g = g + 1) begin : g_mix
            wire [3:0] rc = (g < `AMX_FIRST_ASP2_MIX) ? asp1_rate :
                            (g < `AMX_FIRST_EQ_MIX) ? asp2_rate : effects_rate;
            amx_mixer u_mix ( // R3 R11
                .i_clk  (i_clk),
                .i_rst  (i_rst),
                .i_tick (i_rate_tick[rc]),
                .i_smp  (smp_bus[g*128 +: 128]),
                .i_gain (gain_bus[g*28 +: 28]),
                .o_out  (mix_bus[g*32 +: 32])
            );
        end
        for (g = 0; g < `AMX_NUM_EQ; g = g + 1) begin : g_eqo
            assign o_eq_out[g*24 +: 24] = eq_out_ff[g];
        end
    endgenerate
    assign o_asp1_tx = mix_bus[255:0]; // R8
    assign o_asp2_tx = mix_bus[383:256]; // R8

    // one shared state-variable section walks 4 equalizers x 5 bands per effects tick
    integer si;
    integer ci;
    reg signed [47:0] xin;
    reg signed [47:0] hp;
    reg signed [47:0] bpn;
    reg signed [47:0] lpn;
    reg signed [47:0] pick;
    reg signed [47:0] acc;
    reg        [23:0] eq_in;
    reg        [23:0] y;
    always @* begin
        si    = eq_idx_ff * `AMX_NUM_BAND + band_ff;
        ci    = eq_idx_ff * `AMX_COEF_PER_EQ + band_ff * `AMX_COEF_PER_BAND; // R16
        eq_in = mix_bus[(`AMX_FIRST_EQ_MIX*32 + 8) + eq_idx_ff*32 +: 24]; // R8
        xin   = (band_ff == 3'h0) ? $signed({{24{eq_in[23]}}, eq_in})
                                  : $signed({{24{x_ff[23]}}, x_ff});
        hp    = xin - $signed({{24{lp_ff[si][23]}}, lp_ff[si]})
              - (($signed(coef_ff[ci+1]) * $signed(bp_ff[si])) >>> `AMX_COEF_FRAC);
        hp    = sat24(hp);
        bpn   = $signed({{24{bp_ff[si][23]}}, bp_ff[si]})
              + (($signed(coef_ff[ci]) * hp) >>> `AMX_COEF_FRAC);
        bpn   = sat24(bpn);
        lpn   = $signed({{24{lp_ff[si][23]}}, lp_ff[si]})
              + (($signed(coef_ff[ci]) * bpn) >>> `AMX_COEF_FRAC);
        lpn   = sat24(lpn);
        if (band_ff == 3'h0)
            pick = eq_mode_ff[eq_idx_ff] ? bpn : lpn; // R12
        else if (band_ff == `AMX_LAST_BAND)
            pick = hp; // R14
        else
            pick = bpn; // R13
        acc   = xin + (($signed(coef_ff[ci+2]) * pick) >>> `AMX_COEF_FRAC);
        acc   = sat24(acc);
        y     = acc[23:0];
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            eq_state_ff <= ST_IDLE;
            fx_go_ff    <= 1'b0;
            eq_idx_ff   <= 2'h0;
            band_ff     <= 3'h0;
            x_ff        <= 24'h0;
            eq_valid_ff <= 1'b0;
            for (j = 0; j < `AMX_NUM_STATE; j = j + 1) begin
                lp_ff[j] <= 24'h0;
                bp_ff[j] <= 24'h0;
            end
            for (j = 0; j < `AMX_NUM_EQ; j = j + 1)
                eq_out_ff[j] <= 24'h0;
        end else begin
            // the equalizer mixers load on this tick; the walk starts a cycle later
            fx_go_ff    <= i_rate_tick[effects_rate];
            eq_valid_ff <= 1'b0;
            case (eq_state_ff)
                ST_IDLE: begin
                    if (fx_go_ff) begin
                        eq_state_ff <= ST_RUN;
                        eq_idx_ff   <= 2'h0;
                        band_ff     <= 3'h0;
                    end
                end
                ST_RUN: begin
                    if (eq_en_ff[eq_idx_ff]) begin
                        lp_ff[si] <= lpn[23:0];
                        bp_ff[si] <= bpn[23:0];
                    end
                    x_ff <= y;
                    if (band_ff == `AMX_LAST_BAND) begin
                        // a disabled equalizer passes its mixer output through
                        eq_out_ff[eq_idx_ff] <= eq_en_ff[eq_idx_ff] ? y : eq_in; // R11
                        band_ff              <= 3'h0;
                        eq_idx_ff            <= eq_idx_ff + 2'h1;
                        if (eq_idx_ff == 2'h3) begin
                            eq_state_ff <= ST_IDLE;
                            eq_valid_ff <= 1'b1;
                        end
                    end else begin
                        band_ff <= band_ff + 3'h1;
                    end
                end
                default: eq_state_ff <= ST_IDLE;
            endcase
        end
    end
    assign o_eq_valid = eq_valid_ff;
endmodule // amx_core

// File: amx_defs.vh
`ifndef AMX_DEFS_VH
`define AMX_DEFS_VH
// Overview of operation
// R1: any input path selectable; 0x000 silence, 0x010-0x013 analog, 0x020-0x027 port one
// R2: 0x030-0x033 select port two receive, 0x0D8/0x0D9 select ultrasonic channels
// R3: every serial-port output channel has a four-input mixer with per-input gain
// R4: serial-port output mixer fields sit at 0x8200 through 0x833C
// R5: equalizer input mixer fields sit at 0x8B80 through 0x8BBC
// R6: software clears port mixer sources, waits 125 us, then changes port rate
// R7: software clears equalizer sources, waits 125 us, then changes effects rate
// R8: port output mixers carry 32 bits; other paths truncate to 24 bits
// R9: enabling a path is refused when the system clock is too slow
// R10: mixer status bits show which input paths are enabled
// R11: four equalizers, each fed by its own four-input gain mixer, one output each
// R12: band one is shelving below cut-off or peak around its frequency
// R13: bands two to four are always peak filters
// R14: band five is always a shelving filter above its cut-off
// R15: software runs equalizer, compressor and pass filters at one effects rate
// R16: each equalizer takes band coefficients from its own register range
// R17: software matches source rates to output mixer rate or inserts conversion
// R18: software matches source rates to equalizer rate or inserts conversion
// R19: each input path samples at the rate set by its governing rate field
// R20: gain field bits 7:1, -32 dB to +16 dB in 1 dB steps, reset 0x40
// R21: read-only status bit 15 reads 1 while the path is enabled
// R22: mixer scales, sums four inputs per sample and saturates the result
`define AMX_SRC_ANA_BASE   9'h010
`define AMX_SRC_ANA_MASK   9'h1FC
`define AMX_SRC_ASP1_BASE  9'h020
`define AMX_SRC_ASP1_MASK  9'h1F8
`define AMX_SRC_ASP2_BASE  9'h030
`define AMX_SRC_ASP2_MASK  9'h1FC
`define AMX_SRC_US_BASE    9'h0D8
`define AMX_SRC_US_MASK    9'h1FE
`define AMX_SRC_SILENCE    9'h000
`define AMX_NUM_ANA        4
`define AMX_NUM_ASP1       8
`define AMX_NUM_ASP2       4
`define AMX_NUM_EQ         4
`define AMX_NUM_MIX        16
`define AMX_FIRST_ASP2_MIX 8
`define AMX_FIRST_EQ_MIX   12
`define AMX_NUM_IN         4
`define AMX_NUM_SRCW       64
`define AMX_NUM_BAND       5
`define AMX_LAST_BAND      3'h4
`define AMX_NUM_STATE      20
`define AMX_NUM_COEF       60
`define AMX_COEF_PER_EQ    15
`define AMX_COEF_PER_BAND  3
`define AMX_ASP1_MIX_BASE  16'h8200
`define AMX_ASP2_MIX_BASE  16'h8300
`define AMX_EQ_MIX_BASE    16'h8B80
`define AMX_MIX_STRIDE     16
`define AMX_WORD_BYTES     4
`define AMX_GAIN_BANK      16'h2000
`define AMX_EQ_COEF_BASE   16'hA818
`define AMX_EQ_COEF_STRIDE 68
`define AMX_RATE_ADDR      16'hA000
`define AMX_EQ_EN_ADDR     16'hA808
`define AMX_EQ_MODE_ADDR   16'hA80C
`define AMX_STS_BIT        15
`define AMX_GAIN_RST       7'h40
`define AMX_GAIN_MIN       7'h20
`define AMX_GAIN_MAX       7'h50
`define AMX_GAIN_IDX_OFS   7'h1C
`define AMX_GAIN_STEPS     7'h06
`define AMX_GAIN_FRAC      20
`define AMX_MANT0          16'h4000
`define AMX_MANT1          16'h47D6
`define AMX_MANT2          16'h50A3
`define AMX_MANT3          16'h5A82
`define AMX_MANT4          16'h6598
`define AMX_MANT5          16'h7209
`define AMX_COEF_FRAC      14
`define AMX_RATE_IN_LSB    0
`define AMX_RATE_ASP1_LSB  4
`define AMX_RATE_ASP2_LSB  8
`define AMX_RATE_US1_LSB   12
`define AMX_RATE_US2_LSB   16
`define AMX_RATE_FX_LSB    20
`define AMX_RATE_BITS      24
`endif

// File: amx_mixer.v
`timescale 1ns/1ps
`include "amx_defs.vh"
module amx_mixer (
    input  wire         i_clk,
    input  wire         i_rst,
    input  wire         i_tick,
    input  wire [127:0] i_smp,
    input  wire [27:0]  i_gain,
    output reg  [31:0]  o_out
);
    wire signed [41:0] term [0:3];
    genvar g;
    generate
        for (g = 0; g < `AMX_NUM_IN; g = g + 1) begin : g_in
            wire        [6:0]  code = i_gain[g*7 +: 7];
            // codes below -32 dB or above +16 dB pin to the end values
            wire        [6:0]  clip = (code < `AMX_GAIN_MIN) ? `AMX_GAIN_MIN :
                                      (code > `AMX_GAIN_MAX) ? `AMX_GAIN_MAX : code; // R20
            wire        [6:0]  idx  = clip - `AMX_GAIN_IDX_OFS;
            wire        [6:0]  shw  = idx / `AMX_GAIN_STEPS;
            wire        [6:0]  frw  = idx % `AMX_GAIN_STEPS;
            reg         [15:0] mant;
            wire signed [48:0] prod;
            wire signed [56:0] big;
            always @* begin
                case (frw[2:0])
                    3'h0: mant = `AMX_MANT0;
                    3'h1: mant = `AMX_MANT1;
                    3'h2: mant = `AMX_MANT2;
                    3'h3: mant = `AMX_MANT3;
                    3'h4: mant = `AMX_MANT4;
                    3'h5: mant = `AMX_MANT5;
                    default: mant = `AMX_MANT0;
                endcase
            end
            // 6 dB per shift plus a sixth-octave mantissa; 6 dB taken as x2
            assign prod = $signed(i_smp[g*32 +: 32]) * $signed({1'b0, mant});
            assign big  = {{8{prod[48]}}, prod} <<< shw[3:0];
            assign term[g] = {{5{big[56]}}, big[56:`AMX_GAIN_FRAC]}; // R22
        end
    endgenerate
    wire signed [41:0] sum = term[0] + term[1] + term[2] + term[3];
    wire               ovf = ~(&sum[41:31] | ~|sum[41:31]);
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_out <= 32'h0;
        end else if (i_tick) begin
            o_out <= ovf ? {sum[41], {31{~sum[41]}}} : sum[31:0]; // R22
        end
    end
endmodule // amx_mixer

// File: amx_core_asserts.sv
`timescale 1ns/1ps
module amx_core_chk (
    input logic         i_clk,
    input logic         i_rst,
    input logic         i_hsel,
    input logic [1:0]   i_htrans,
    input logic         i_hwrite,
    input logic         i_hready,
    input logic [31:0]  o_hrdata,
    input logic         o_hreadyout,
    input logic [15:0]  i_rate_tick,
    input logic [255:0] o_asp1_tx,
    input logic [127:0] o_asp2_tx,
    input logic         o_eq_valid
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_req;
        i_hsel && i_hready && i_htrans[1];
    endsequence
    sequence s_rd_dp;
        !o_hreadyout ##1 o_hreadyout;
    endsequence
    property p_rd;
        s_req ##0 !i_hwrite |=> s_rd_dp;
    endproperty
    a_rd: assert property (p_rd) else $error("read wait state wrong");
    property p_wr;
        s_req ##0 i_hwrite |=> o_hreadyout;
    endproperty
    a_wr: assert property (p_wr) else $error("write data phase stalled");
    property p_one_wait;
        !o_hreadyout |=> o_hreadyout;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");
    property p_hold;
        $changed(o_hrdata) |-> $past(!o_hreadyout);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved outside a read");
    property p_a1;
        $changed(o_asp1_tx) |-> $past(|i_rate_tick);
    endproperty
    a_a1: assert property (p_a1) else $error("port one output moved without tick");
    property p_a2;
        $changed(o_asp2_tx) |-> $past(|i_rate_tick);
    endproperty
    a_a2: assert property (p_a2) else $error("port two output moved without tick");
    property p_eqv;
        o_eq_valid |=> !o_eq_valid;
    endproperty
    a_eqv: assert property (p_eqv) else $error("eq valid longer than one cycle");
    property p_eqlat;
        $rose(o_eq_valid) |-> $past(|i_rate_tick, 21) || $past(|i_rate_tick, 22);
    endproperty
    a_eqlat: assert property (p_eqlat) else $error("eq result at wrong distance from tick");
endmodule // amx_core_chk
bind amx_core amx_core_chk chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(i_hsel), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .i_rate_tick(i_rate_tick), .o_asp1_tx(o_asp1_tx), .o_asp2_tx(o_asp2_tx), .o_eq_valid(o_eq_valid));

// File: amx_src_model.sv
`timescale 1ns/1ps
module amx_src_model (
    input  logic        i_clk,
    input  logic        i_rst,
    output logic [15:0] o_tick
);
    logic [5:0] cnt_ff;
    // all rate codes tick together, so every source matches its sink's rate
    always @(posedge i_clk) begin
        if (i_rst) begin
            cnt_ff <= 6'h00;
            o_tick <= 16'h0000;
        end else begin
            cnt_ff <= (cnt_ff == 6'h27) ? 6'h00 : cnt_ff + 6'h01;
            o_tick <= {16{cnt_ff == 6'h27}};
        end
    end
endmodule // amx_src_model

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic         i_clk = 0, i_rst = 1, hsel = 0, hwrite = 0, ck_ok = 1;
    logic [31:0]  haddr = 0, hwdata = 0, rd;
    logic [1:0]   htrans = 0;
    logic [15:0]  tick;
    logic [95:0]  ana = 0;
    logic [255:0] a1 = 0;
    logic [127:0] a2 = 0;
    logic [47:0]  us = 0;
    wire  [31:0]  hrdata;
    wire          hrdy, hresp;
    wire  [255:0] tx1;
    wire  [127:0] tx2;
    wire  [95:0]  eqo;
    int           err_total = 0, total_checks = 0, cyc = 0, ex;
    logic [8:0]   codes[10] = '{9'h010, 9'h013, 9'h020, 9'h027, 9'h030, 9'h033, 9'h0D8, 9'h0D9, 9'h000, 9'h011};
    logic [6:0]   gn[3] = '{7'h46, 7'h3A, 7'h4C};
    logic [31:0]  ge[3] = '{32'h02000000, 32'h00800000, 32'h04000000};
    always #20 i_clk = ~i_clk;
    amx_src_model src_u (.i_clk(i_clk), .i_rst(i_rst), .o_tick(tick));
    amx_core dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
        .o_hreadyout(hrdy), .o_hresp(hresp), .i_core_system_clock_ok(ck_ok), .i_rate_tick(tick),
        .i_analog_in(ana), .i_asp1_rx(a1), .i_asp2_rx(a2), .i_ultrasonic_in(us), .o_asp1_tx(tx1),
        .o_asp2_tx(tx2), .o_eq_out(eqo), .o_eq_valid());
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge i_clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge i_clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdc(logic [31:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("reg", e, rd);
        chk("resp", 32'h0, {31'h0, hresp});
    endtask
    // three ticks: capture, mix, and one spare so the eq walk also finishes
    task automatic settle();
        repeat (3) begin
            @(posedge i_clk);
            while (tick[0] !== 1'b1) @(posedge i_clk);
        end
        repeat (2) @(posedge i_clk);
    endtask
    function automatic logic [31:0] smp(int c);
        if (c >= 16 && c < 20) return {ana[(c - 16) * 24 +: 24], 8'h00};
        if (c >= 32 && c < 40) return a1[(c - 32) * 32 +: 32];
        if (c >= 48 && c < 52) return a2[(c - 48) * 32 +: 32];
        if (c >= 216 && c < 218) return {us[(c - 216) * 24 +: 24], 8'h00};
        return 32'h0;
    endfunction
    initial begin
        void'($urandom(70));
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        ana <= {$urandom, $urandom, $urandom};
        a2 <= {$urandom, $urandom, $urandom, $urandom};
        us <= 48'({$urandom, $urandom});
        a1 <= {32'h70000000, 32'h01000000, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
        @(posedge i_clk);
        rdc(32'h8200, 32'h0);
        rdc(32'hA200, 32'h80);
        rdc(32'h9000, 32'h0);
        ck_ok <= 1'b0;
        bus(1'b1, 32'h8200, 32'h20);
        rdc(32'h8200, 32'h0);
        ck_ok <= 1'b1;
        foreach (codes[i]) begin
            bus(1'b1, 32'h8200, 32'(codes[i]));
            bus(1'b1, 32'h8300, 32'(codes[i]));
            settle();
            chk("tx1", smp(codes[i]), tx1[31:0]);
            chk("tx2", smp(codes[i]), tx2[31:0]);
            rdc(32'h8200, {16'h0, codes[i] != 0, 6'h00, codes[i]});
        end
        ck_ok <= 1'b0;
        bus(1'b1, 32'h8200, 32'h26);
        rdc(32'h8200, 32'h8026);
        ck_ok <= 1'b1;
        foreach (gn[i]) begin
            bus(1'b1, 32'hA200, {24'h0, gn[i], 1'b0});
            settle();
            chk("gain", ge[i], tx1[31:0]);
        end
        bus(1'b1, 32'hA200, 32'h80);
        bus(1'b1, 32'h8200, 32'h27);
        bus(1'b1, 32'h8204, 32'h27);
        settle();
        chk("sat", 32'h7FFFFFFF, tx1[31:0]);
        bus(1'b1, 32'h833C, 32'hD9);
        rdc(32'h833C, 32'h80D9);
        bus(1'b1, 32'h8BBC, 32'hD8);
        rdc(32'h8BBC, 32'h80D8);
        bus(1'b1, 32'hA91C, 32'h5A3C);
        rdc(32'hA91C, 32'h5A3C);
        foreach (ge[i]) bus(1'b1, 32'h8200 + 32'(i) * 32'h4, 32'h0);
        bus(1'b1, 32'h8300, 32'h0);
        bus(1'b1, 32'h833C, 32'h0);
        bus(1'b1, 32'h8BBC, 32'h0);
        repeat (3125) @(posedge i_clk);
        bus(1'b1, 32'hA000, 32'h111111);
        bus(1'b1, 32'h8B80, 32'h20);
        settle();
        chk("eq", {8'h00, a1[31:8]}, {8'h00, eqo[23:0]});
        // zero frequency words keep the state at rest, so band five adds boost times input
        ex = int'($signed(a1[31:8]));
        ex = ex + ((-ex) >>> 1);
        bus(1'b1, 32'hA850, 32'hE000);
        bus(1'b1, 32'hA808, 32'h1);
        settle();
        chk("eq5", 32'(ex), {{8{eqo[23]}}, eqo[23:0]});
        report_and_stop();
    end
endmodule // tb_top
